// ===== dv/pllsc_host.sv
`timescale 1ns/1ps
`default_nettype none

module pllsc_host #(
	parameter int WORD_W = 18
) (
	// Pacing clock
	input  wire logic clock,
	// Serial load link
	output logic      serial_clk,
	output logic      serial_data,
	output logic      load_strobe
);

	// Idle link: clock low, strobe low
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end

	// Shift one word, 200 ns per bit
	task automatic shift_word(input logic [WORD_W-1:0] w);
		@(posedge clock);
		for (int i = WORD_W - 1; i >= 0; i--) begin
			serial_data <= w[i];
			repeat (4) @(posedge clock);
			serial_clk <= 1'b1;
			repeat (4) @(posedge clock);
			serial_clk <= 1'b0;
		end
		repeat (4) @(posedge clock);
		serial_data <= ~w[0]; // Released line shows no stale bit
	endtask

	// Move strobe only while serial clock rests low
	task automatic set_strobe(input logic lvl);
		@(posedge clock);
		load_strobe <= lvl;
	endtask

endmodule

`default_nettype wire

// ===== dv/pllsc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module pllsc_tb_top;
	import pllsc_pkg::*;

	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        serial_clk;
	logic        serial_data;
	logic        load_strobe;
	logic        power_down_n = 1'b1;
	logic        phase_polarity_select = 1'b1;
	logic        prescaler_in = 1'b0;
	logic        reference_osc_in = 1'b0;
	logic        cp_up;
	logic        cp_down;
	logic        lock_indicator;
	logic        monitor_out;
	logic        loop_switch_out;
	logic        power_save;
	logic        irq;
	int          miscompares = 0;
	int          total_checks = 0;

	always #12.5 clock = ~clock;

	pllsc_top u_pllsc_top (.clock(clock), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_clk(serial_clk),
		.serial_data(serial_data), .load_strobe(load_strobe),
		.phase_polarity_select(phase_polarity_select),
		.power_down_n(power_down_n), .prescaler_in(prescaler_in),
		.reference_osc_in(reference_osc_in), .cp_up(cp_up),
		.cp_down(cp_down), .loop_switch_out(loop_switch_out),
		.lock_indicator(lock_indicator), .monitor_out(monitor_out),
		.power_save(power_save), .irq(irq));

	pllsc_host u_pllsc_host (.clock(clock), .serial_clk(serial_clk),
		.serial_data(serial_data), .load_strobe(load_strobe));

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// One Avalon access, held until waitrequest low
	task automatic acc(input logic wr, input logic [4:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk({31'h0, avs_waitrequest}, 32'h0);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] t;
		acc(1'b1, a, d, t);
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] t;
		acc(1'b0, a, 32'h0, t);
		chk(t, exp);
	endtask

	// Reset values, read-only and unmapped places, control field
	task automatic t_regs();
		rchk(OFF_CTRL, 32'h0);
		rchk(OFF_STAT, 32'h0);
		rchk(OFF_MASK, 32'h0);
		rchk(OFF_STATE, 32'h0);
		rchk(OFF_RLAT, 32'h0);
		rchk(OFF_NLAT, 32'h0);
		rchk(5'h18, 32'h0);
		wr(OFF_CTRL, 32'h3);
		rchk(OFF_CTRL, 32'h3);
		wr(OFF_CTRL, 32'h0);
		rchk(OFF_CTRL, 32'h0);
		wr(OFF_RLAT, 32'hFFFF_FFFF);
		rchk(OFF_RLAT, 32'h0);
	endtask

	// Shift a word, check latch held, then strobe it in
	task automatic send(input logic [17:0] w, input logic [4:0] a,
		input logic [31:0] old);
		u_pllsc_host.shift_word(w);
		rchk(a, old);
		u_pllsc_host.set_strobe(1'b1);
		repeat (10) @(posedge clock);
		chk({31'h0, loop_switch_out}, 32'h1);
		rchk(OFF_STATE, 32'h10);
		u_pllsc_host.set_strobe(1'b0);
		repeat (10) @(posedge clock);
		chk({31'h0, loop_switch_out}, 32'h0);
		rchk(a, {15'h0, w[17:1]});
	endtask

	// Both latches, status, mask and interrupt
	task automatic t_load();
		wr(OFF_MASK, 32'h1);
		send({17'h05432, 1'b0}, OFF_NLAT, 32'h0);
		rchk(OFF_STAT, 32'h2);
		chk({31'h0, irq}, 32'h0);
		send({17'h1ABCD, 1'b1}, OFF_RLAT, 32'h0);
		rchk(OFF_NLAT, 32'h5432);
		rchk(OFF_STAT, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wr(OFF_STAT, 32'h1);
		rchk(OFF_STAT, 32'h2);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_STAT, 32'h1F);
	endtask

	// Power-down entry with idle pump, then wake
	task automatic t_pd();
		int n;
		@(posedge clock);
		power_down_n <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (power_save !== 1'b1 && n < 30);
		chk({31'h0, power_save}, 32'h1);
		rchk(OFF_STAT, 32'h10);
		@(posedge clock);
		power_down_n <= 1'b1;
		repeat (20) @(posedge clock);
		chk({31'h0, power_save}, 32'h0);
	endtask

	// Pulse one divider input n times, counting monitor pulses
	task automatic pulse_in(input logic vco, input int n,
		output int hits);
		hits = 0;
		@(posedge clock);
		for (int i = 0; i < n; i++) begin
			if (vco) prescaler_in <= 1'b1;
			else reference_osc_in <= 1'b1;
			repeat (4) begin
				@(posedge clock);
				if (monitor_out === 1'b1) hits++;
			end
			prescaler_in <= 1'b0;
			reference_osc_in <= 1'b0;
			repeat (4) begin
				@(posedge clock);
				if (monitor_out === 1'b1) hits++;
			end
		end
		repeat (8) begin
			@(posedge clock);
			if (monitor_out === 1'b1) hits++;
		end
	endtask

	// Pump polarity, monitor, gated power-down, ratios, lock
	task automatic t_pump();
		int hits;
		send({17'h00001, 1'b1}, OFF_RLAT, 32'h1ABCD);
		send({17'h00080, 1'b0}, OFF_NLAT, 32'h5432);
		wr(OFF_CTRL, 32'h0);
		pulse_in(1'b0, 1, hits);
		chk(hits, 32'h1);
		chk({30'h0, cp_down, cp_up}, 32'h1);
		phase_polarity_select <= 1'b0;
		repeat (10) @(posedge clock);
		chk({30'h0, cp_down, cp_up}, 32'h2);
		phase_polarity_select <= 1'b1;
		power_down_n <= 1'b0;
		repeat (20) @(posedge clock);
		chk({31'h0, power_save}, 32'h0);
		power_down_n <= 1'b1;
		wr(OFF_CTRL, 32'h2);
		pulse_in(1'b1, 64, hits);
		chk(hits, 32'h1);
		rchk(OFF_STATE, 32'h0);
		wr(OFF_CTRL, 32'h3);
		pulse_in(1'b1, 64, hits);
		chk(hits, 32'h0);
		pulse_in(1'b1, 64, hits);
		chk(hits, 32'h1);
		pulse_in(1'b0, 1, hits);
		chk(hits, 32'h0);
		send({17'h00001, 1'b0}, OFF_NLAT, 32'h80);
		@(posedge clock);
		reference_osc_in <= 1'b1;
		@(posedge clock);
		prescaler_in <= 1'b1;
		repeat (4) @(posedge clock);
		reference_osc_in <= 1'b0;
		prescaler_in <= 1'b0;
		repeat (10) @(posedge clock);
		chk({31'h0, lock_indicator}, 32'h1);
		rchk(OFF_STATE, 32'h3);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		repeat (6) @(posedge clock);
		t_regs();
		t_load();
		t_pd();
		t_pump();
		report_and_stop();
	end

	// Watchdog, far beyond the expected 2658 cycles
	initial begin
		#200us;
		miscompares++;
		report_and_stop();
	end

endmodule

`default_nettype wire

// ===== src/pllsc_pkg.sv
package pllsc_pkg;

	// Register byte offsets
	localparam logic [4:0] OFF_CTRL  = 5'h00;
	localparam logic [4:0] OFF_STAT  = 5'h04;
	localparam logic [4:0] OFF_MASK  = 5'h08;
	localparam logic [4:0] OFF_STATE = 5'h0C;
	localparam logic [4:0] OFF_RLAT  = 5'h10;
	localparam logic [4:0] OFF_NLAT  = 5'h14;

	// Control fields
	localparam int CTRL_PRE128 = 0;
	localparam int CTRL_MONVCO = 1;
	localparam int CTRL_W      = 2;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// Event bits, shared by status and mask
	localparam int EV_RLOAD  = 0;
	localparam int EV_NLOAD  = 1;
	localparam int EV_LOCK   = 2;
	localparam int EV_UNLOCK = 3;
	localparam int EV_PD     = 4;
	localparam int EV_W      = 5;
	localparam logic [4:0] EV_RST = 5'h00;

	// Pin slots of the input synchroniser
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDAT = 1;
	localparam int PIN_LE   = 2;
	localparam int PIN_POL  = 3;
	localparam int PIN_PDN  = 4;
	localparam int PIN_VCO  = 5;
	localparam int PIN_REF  = 6;
	localparam int PIN_N    = 7;
	// Pulled-up pins rest high
	localparam logic [6:0] PIN_RST = 7'h1C;

	// Prescaler pairs: low modulus bits of the swallow field
	localparam int SWALLOW_W = 7;

	// Lock window: longest phase error still counted as locked
	localparam int CLK_PERIOD_NS = 25;
	localparam int LOCK_WIN_NS   = 75;
	localparam int LOCK_WIN_CYC  = (LOCK_WIN_NS / CLK_PERIOD_NS < 1) ?
		1 : LOCK_WIN_NS / CLK_PERIOD_NS;
	localparam int WID_W = 8;

	// Power-down sequencing
	typedef enum logic [1:0] {
		PD_RUN  = 2'b00,
		PD_WAIT = 2'b01,
		PD_OFF  = 2'b11
	} pllsc_pd_t;

endpackage

// ===== src/pllsc_top.sv
// Functional notes
// - Shift data on each serial clock rise
// - Words arrive MSB first; LSB picks latch
// - Load strobe rise copies word into latch
// - Low polarity select swaps pump direction
// - Loop switch closed while strobe is high
// - Lock indicator high, narrow lows when locked
// - Power-down input low requests power saving
// - Power-down waits for idle charge pump
// - Prescaler divides by 64/65 or 128/129
// - Logic output monitors phase comparator input
`timescale 1ns/1ps
`default_nettype none

module pllsc_top
	import pllsc_pkg::*;
#(
	parameter int WORD_W = 18
) (
	// System
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Serial load link
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        load_strobe,
	// Synthesizer pins
	input  wire logic        phase_polarity_select,
	input  wire logic        power_down_n,
	input  wire logic        prescaler_in,
	input  wire logic        reference_osc_in,
	// Outputs
	output logic             cp_up,
	output logic             cp_down,
	output logic             loop_switch_out,
	output logic             lock_indicator,
	output logic             monitor_out,
	output logic             power_save,
	output logic             irq
);

	localparam int LAT_W = WORD_W - 1;
	localparam int CNT_W = WORD_W + 1;
	localparam int B_W   = LAT_W - SWALLOW_W;

	// Register hit decode
	function automatic logic reg_hit(input logic [4:0] a,
		input logic [4:0] off);
		reg_hit = (a == off);
	endfunction

	// Input synchroniser, three stages plus agreement filter
	logic [PIN_N-1:0] sy1_q;
	logic [PIN_N-1:0] sy2_q;
	logic [PIN_N-1:0] sy3_q;
	logic [PIN_N-1:0] pin_q;
	logic [PIN_N-1:0] prev_q;
	wire  [PIN_N-1:0] pin_raw;
	wire  [PIN_N-1:0] agree;
	wire  [PIN_N-1:0] pin_d;
	wire  [PIN_N-1:0] rise;

	assign pin_raw = {reference_osc_in, prescaler_in, power_down_n,
		phase_polarity_select, load_strobe, serial_data, serial_clk};
	assign agree = sy2_q ~^ sy3_q;
	assign pin_d = (agree & sy3_q) | (~agree & pin_q);
	assign rise  = pin_q & ~prev_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sy1_q  <= PIN_RST;
			sy2_q  <= PIN_RST;
			sy3_q  <= PIN_RST;
			pin_q  <= PIN_RST;
			prev_q <= PIN_RST;
		end else begin
			sy1_q  <= pin_raw;
			sy2_q  <= sy1_q;
			sy3_q  <= sy2_q;
			pin_q  <= pin_d;
			prev_q <= pin_q;
		end
	end

	// Serial shift register and latches
	logic [WORD_W-1:0] shift_q;
	logic [LAT_W-1:0]  rlat_q;
	logic [LAT_W-1:0]  nlat_q;
	wire               ld_r;
	wire               ld_n;

	assign ld_r = rise[PIN_LE] & shift_q[0];
	assign ld_n = rise[PIN_LE] & ~shift_q[0];

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= '0;
		end else if (rise[PIN_SCLK]) begin
			shift_q <= {shift_q[WORD_W-2:0], pin_q[PIN_SDAT]};
		end
	end

	// Only a strobe rise touches a latch
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rlat_q <= '0;
			nlat_q <= '0;
		end else begin
			if (ld_r) rlat_q <= shift_q[WORD_W-1:1];
			if (ld_n) nlat_q <= shift_q[WORD_W-1:1];
		end
	end

	// Control register fields
	logic [CTRL_W-1:0] ctrl_q;
	wire               pre128;
	wire               mon_vco;

	assign pre128  = ctrl_q[CTRL_PRE128];
	assign mon_vco = ctrl_q[CTRL_MONVCO];

	// Main divide ratio from swallow and prescaler counts
	wire [SWALLOW_W-1:0] a_cnt;
	wire [B_W-1:0]       b_cnt;
	wire [CNT_W-1:0]     n_total;

	assign a_cnt   = nlat_q[SWALLOW_W-1:0];
	assign b_cnt   = nlat_q[LAT_W-1:SWALLOW_W];
	assign n_total = (pre128 ? {2'b00, b_cnt, 7'h00} :
		{3'b000, b_cnt, 6'h00}) + {{(CNT_W-SWALLOW_W){1'b0}}, a_cnt};

	// Power-down state
	pllsc_pd_t pd_q;
	pllsc_pd_t pd_d;
	wire       run;

	assign run = (pd_q != PD_OFF);

	// Dividers on sampled input edges
	logic [CNT_W-1:0] vco_cnt_q;
	logic [LAT_W-1:0] ref_cnt_q;
	logic             vco_div_q;
	logic             ref_div_q;
	wire              vco_last;
	wire              ref_last;
	wire              vco_step;
	wire              ref_step;

	assign vco_last = (vco_cnt_q + 1'b1 >= n_total);
	assign ref_last = ({1'b0, ref_cnt_q} + 1'b1 >= {1'b0, rlat_q});
	assign vco_step = rise[PIN_VCO] & run;
	assign ref_step = rise[PIN_REF] & run;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			vco_cnt_q <= '0;
			ref_cnt_q <= '0;
			vco_div_q <= 1'b0;
			ref_div_q <= 1'b0;
		end else begin
			vco_div_q <= vco_step & vco_last;
			ref_div_q <= ref_step & ref_last;
			if (vco_step) vco_cnt_q <= vco_last ? '0 : vco_cnt_q + 1'b1;
			if (ref_step) ref_cnt_q <= ref_last ? '0 : ref_cnt_q + 1'b1;
		end
	end

	// Phase-frequency comparator
	logic             pfd_up_q;
	logic             pfd_dn_q;
	logic [WID_W-1:0] wid_q;
	logic             lock_q;
	wire              up_n;
	wire              dn_n;
	wire              pfd_act;
	wire              pfd_end;
	wire              lock_d;

	assign up_n    = run & (pfd_up_q | ref_div_q) & ~(pfd_dn_q | vco_div_q);
	assign dn_n    = run & (pfd_dn_q | vco_div_q) & ~(pfd_up_q | ref_div_q);
	assign pfd_act = pfd_up_q | pfd_dn_q;
	assign pfd_end = pfd_act & ~up_n & ~dn_n;
	assign lock_d  = pfd_end ? (wid_q < WID_W'(LOCK_WIN_CYC)) : lock_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pfd_up_q <= 1'b0;
			pfd_dn_q <= 1'b0;
			wid_q    <= '0;
			lock_q   <= 1'b0;
		end else begin
			pfd_up_q <= up_n;
			pfd_dn_q <= dn_n;
			wid_q    <= pfd_act ? wid_q + (&wid_q ? 1'b0 : 1'b1) : '0;
			lock_q   <= lock_d;
		end
	end

	// Power-down sequencer
	always_comb begin
		pd_d = pd_q;
		case (pd_q)
			PD_RUN: if (!pin_q[PIN_PDN]) pd_d = PD_WAIT;
			PD_WAIT: if (pin_q[PIN_PDN]) pd_d = PD_RUN;
				else if (!pfd_act) pd_d = PD_OFF;
			PD_OFF: if (pin_q[PIN_PDN]) pd_d = PD_RUN;
			default: pd_d = PD_RUN;
		endcase
	end

	// Pin outputs
	logic cp_up_q;
	logic cp_dn_q;
	logic loop_sw_q;
	logic lock_ind_q;
	logic mon_q;
	logic psave_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pd_q       <= PD_RUN;
			cp_up_q    <= 1'b0;
			cp_dn_q    <= 1'b0;
			loop_sw_q  <= 1'b0;
			lock_ind_q <= 1'b0;
			mon_q      <= 1'b0;
			psave_q    <= 1'b0;
		end else begin
			pd_q       <= pd_d;
			cp_up_q    <= pin_q[PIN_POL] ? pfd_up_q : pfd_dn_q;
			cp_dn_q    <= pin_q[PIN_POL] ? pfd_dn_q : pfd_up_q;
			loop_sw_q  <= pin_q[PIN_LE];
			lock_ind_q <= lock_q & ~pfd_act;
			mon_q      <= mon_vco ? vco_div_q : ref_div_q;
			psave_q    <= (pd_d == PD_OFF);
		end
	end

	// Avalon handshake: one wait cycle, then answer
	logic        wait_q;
	logic [31:0] rdata_q;
	wire         req;
	wire         wr_now;
	wire         wr_lo;
	wire [31:0]  rdata_d;
	logic [EV_W-1:0] stat_q;
	logic [EV_W-1:0] mask_q;
	logic            irq_q;
	logic            lock_prev_q;

	assign req    = avs_read | avs_write;
	assign wr_now = avs_write & ~wait_q;
	assign wr_lo  = wr_now & avs_byteenable[0];
	assign rdata_d =
		reg_hit(avs_address, OFF_CTRL)  ? {30'h0, ctrl_q} :
		reg_hit(avs_address, OFF_STAT)  ? {27'h0, stat_q} :
		reg_hit(avs_address, OFF_MASK)  ? {27'h0, mask_q} :
		reg_hit(avs_address, OFF_STATE) ? {26'h0, psave_q, loop_sw_q,
			cp_dn_q, cp_up_q, lock_ind_q, lock_q} :
		reg_hit(avs_address, OFF_RLAT)  ? 32'(rlat_q) :
		reg_hit(avs_address, OFF_NLAT)  ? 32'(nlat_q) : 32'h0;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			wait_q <= ~(req & wait_q);
			if (avs_read & wait_q) rdata_q <= rdata_d;
		end
	end

	// Events and interrupt; a new event beats a clear
	wire [EV_W-1:0] ev;
	wire [EV_W-1:0] clr;
	wire [EV_W-1:0] stat_d;
	wire [EV_W-1:0] mask_d;

	assign ev = {(pd_d == PD_OFF) & run, lock_prev_q & ~lock_q,
		~lock_prev_q & lock_q, ld_n, ld_r};
	assign clr = (wr_lo & reg_hit(avs_address, OFF_STAT)) ?
		avs_writedata[EV_W-1:0] : '0;
	assign stat_d = (stat_q & ~clr) | ev;
	assign mask_d = (wr_lo & reg_hit(avs_address, OFF_MASK)) ?
		avs_writedata[EV_W-1:0] : mask_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q      <= CTRL_RST;
			stat_q      <= EV_RST;
			mask_q      <= EV_RST;
			irq_q       <= 1'b0;
			lock_prev_q <= 1'b0;
		end else begin
			if (wr_lo & reg_hit(avs_address, OFF_CTRL))
				ctrl_q <= avs_writedata[CTRL_W-1:0];
			stat_q      <= stat_d;
			mask_q      <= mask_d;
			irq_q       <= |(stat_d & mask_d);
			lock_prev_q <= lock_q;
		end
	end

	// Output drive
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign cp_up           = cp_up_q;
	assign cp_down         = cp_dn_q;
	assign loop_switch_out = loop_sw_q;
	assign lock_indicator  = lock_ind_q;
	assign monitor_out     = mon_q;
	assign power_save      = psave_q;
	assign irq             = irq_q;

	// Checks on serial loading
	AST_SHIFT_IN: assert property (@(posedge clock) disable iff (!reset_n)
		rise[PIN_SCLK] |=> shift_q[0] == $past(pin_q[PIN_SDAT]))
		else $error("serial bit not shifted in");
	AST_MSB_FIRST: assert property (@(posedge clock) disable iff (!reset_n)
		rise[PIN_SCLK] |=> shift_q[WORD_W-1:1] == $past(shift_q[WORD_W-2:0]))
		else $error("shift order wrong");
	AST_LOAD_REF: assert property (@(posedge clock) disable iff (!reset_n)
		rise[PIN_LE] && shift_q[0] |=> rlat_q == $past(shift_q[WORD_W-1:1]))
		else $error("reference latch not loaded");
	AST_LOAD_MAIN: assert property (@(posedge clock) disable iff (!reset_n)
		rise[PIN_LE] && !shift_q[0] |=> nlat_q == $past(shift_q[WORD_W-1:1]))
		else $error("main latch not loaded");
	AST_LATCH_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
		!rise[PIN_LE] |=> $stable(rlat_q) && $stable(nlat_q))
		else $error("latch changed without strobe");

	// Checks on pump, switch, lock, power-down, divider and monitor
	AST_POL_SWAP: assert property (@(posedge clock) disable iff (!reset_n)
		!pin_q[PIN_POL] && pfd_up_q |=> cp_dn_q && !cp_up_q)
		else $error("polarity not reversed");
	AST_POL_NORM: assert property (@(posedge clock) disable iff (!reset_n)
		pin_q[PIN_POL] && pfd_up_q |=> cp_up_q && !cp_dn_q)
		else $error("normal polarity broken");
	AST_LOOP_SW: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(pin_q[PIN_LE]) |=> loop_sw_q ##1 (loop_sw_q || !$past(pin_q[PIN_LE])))
		else $error("loop switch not following strobe");
	AST_LOCK_IND: assert property (@(posedge clock) disable iff (!reset_n)
		lock_q && !pfd_act |=> lock_ind_q)
		else $error("lock indicator low while locked and idle");
	AST_PD_REQ: assert property (@(posedge clock) disable iff (!reset_n)
		pd_q == PD_WAIT && !pin_q[PIN_PDN] && !pfd_act |=> psave_q)
		else $error("power-down not entered");
	AST_PD_GATE: assert property (@(posedge clock) disable iff (!reset_n)
		pd_q == PD_WAIT && pfd_act |=> pd_q != PD_OFF)
		else $error("power-down while pump active");
	AST_DIV_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
		vco_step && vco_last |=> vco_div_q && vco_cnt_q == '0)
		else $error("main divider did not wrap");
	AST_MONITOR: assert property (@(posedge clock) disable iff (!reset_n)
		ref_div_q && !mon_vco |=> mon_q)
		else $error("monitor missed reference pulse");

endmodule

`default_nettype wire
